/* File: design/meter_ctrl.sv */
// control, status and readout logic of the panel meter
`timescale 1ns/1ps
module meter_ctrl #(
    parameter int SIG_LEN = meter_pkg::SIG_CYCLES,
    parameter int REF_LEN = meter_pkg::REF_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter result interface
    input wire logic [14:0] adc_count,
    input wire logic adc_negative,
    // asynchronous pins
    input wire logic run_freeze,
    input wire logic readout_off_n,
    input wire logic seg_check,
    input wire logic sign_show_en,
    input wire logic [3:0] radix_sel_n,
    // status pins
    output logic sign_out_n,
    output logic low_reading_flag,
    output logic over_limit_flag,
    output logic conv_active,
    // readout
    output logic [1:0] leading_digit,
    output logic [11:0] digits_bcd,
    output logic [2:0] digit_blank,
    output logic [3:0] radix_on,
    output logic sign_plus,
    output logic sign_minus,
    // interrupt
    output logic irq
);
    import meter_pkg::*;

    // ****************************************************
    // overview
    // ****************************************************
    // the block sits behind the front-panel pins of the meter and
    // software reaches its registers over a zero-wait apb slave.
    // the analog converter is outside; it hands over a magnitude
    // count and a polarity bit that are taken once per measurement,
    // on the last cycle of the reference phase.
    //
    // measurement sequencer:
    // - idle waits while the freeze level is active and starts a
    //   new measurement on the first cycle it is not
    // - signal phase lasts SIG_LEN cycles; entering it drops the
    //   low-reading flag and raises conversion-active
    // - reference phase lasts REF_LEN cycles; entering it drops the
    //   over-limit flag, so that flag stands for a whole signal phase
    // - on the last reference cycle the count is latched, both flags
    //   are set from it, conversion-active falls and events are posted
    // - done is one spare cycle back to idle, so a freeze that lands
    //   during a measurement lets that measurement finish first
    //
    // register access:
    // - read data is captured in the setup cycle and held through
    //   the access phase, so the master sees it at the edge at which
    //   it samples pready; it returns to zero afterwards
    // - writes take effect at the access edge only
    // - the event status is cleared by a read at the access edge;
    //   an event posted in that same cycle survives the clear, but an
    //   event posted in the setup cycle is cleared without being read
    //
    // readout priority, highest first:
    // - segment test pattern, when enabled and at its active level
    // - blanking of the digits, leaving points and sign visible
    // - overscale: leading one with the other digits blanked and
    //   the sign that matches the latched polarity
    // - the plain reading split into decimal digits
    //
    // hazards and limits:
    // - every pin is taken through two flops; a pin change shows two
    //   edges later and a pulse shorter than a clock may be missed
    // - the synchroniser resets to the idle levels of the pins so
    //   that no false freeze, blank or test shows after reset
    // - the digit split uses division by constants; the count is at
    //   most 15 bits so the depth of that logic stays small
    // - the freeze sense and test polarity live in the control
    //   register so one build serves both pin variants

    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic [8:0] s1;           // first sync stage
        logic [8:0] s2;           // second sync stage
        phase_type phase;         // sequencer phase
        logic [31:0] cnt;         // phase counter
        logic [14:0] result;      // latched count
        logic neg;                // latched polarity
        logic over;               // over-limit flag
        logic low;                // low-reading flag
        logic over_pend;          // spare bit, reset low and never set or read
        logic busy;               // conversion active
        logic [31:0] ctrl;        // control register
        logic [IRQ_W-1:0] ist;    // sticky events
        logic [IRQ_W-1:0] imask;  // event mask
        logic [31:0] rdata;       // read data
        logic [15:0] nsample;     // finished samples
    } state_type;

    state_type st_r;
    state_type st_nxt;
    logic [8:0] pins;
    logic sync_run;
    logic sync_off_n;
    logic sync_test;
    logic sync_sign_en;
    logic [3:0] sync_radix_n;
    logic freeze;
    logic test_on;
    logic blank;
    logic acc;
    logic [IRQ_W-1:0] ev;
    logic [3:0] d0;
    logic [3:0] d1;
    logic [3:0] d2;
    logic [3:0] d3;

    assign pins = {radix_sel_n, sign_show_en, seg_check, readout_off_n, run_freeze, 1'b0};
    assign sync_run = st_r.s2[1];
    assign sync_off_n = st_r.s2[2];
    assign sync_test = st_r.s2[3];
    assign sync_sign_en = st_r.s2[4];
    assign sync_radix_n = st_r.s2[8:5];
    assign acc = psel & penable;

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        st_nxt = st_r;
        ev = '0;
        // two-stage synchroniser for pins
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        // freeze sense chosen by variant bit
        if (st_r.ctrl[CTRL_VARIANT_BIT]) begin
            freeze = sync_run;
        end else begin
            freeze = ~sync_run;
        end
        // measurement sequencer
        unique case (st_r.phase)
            IDLE: begin
                if (!freeze) begin
                    st_nxt.phase = SIG_INT;
                    st_nxt.cnt = '0;
                    st_nxt.busy = 1'b1;
                    st_nxt.low = 1'b0;
                end
            end
            SIG_INT: begin
                st_nxt.cnt = st_r.cnt + 32'h1;
                if (st_r.cnt == 32'(SIG_LEN - 1)) begin
                    st_nxt.phase = REF_INT;
                    st_nxt.cnt = '0;
                    st_nxt.over = 1'b0;
                end
            end
            REF_INT: begin
                st_nxt.cnt = st_r.cnt + 32'h1;
                if (st_r.cnt == 32'(REF_LEN - 1)) begin
                    st_nxt.phase = DONE;
                    st_nxt.result = adc_count;
                    st_nxt.neg = adc_negative;
                    st_nxt.over = (adc_count > OVER_LIMIT);
                    st_nxt.low = (adc_count <= LOW_LIMIT);
                    st_nxt.busy = 1'b0;
                    st_nxt.nsample = st_r.nsample + 16'h1;
                    ev[IRQ_DONE_BIT] = 1'b1;
                    ev[IRQ_OVER_BIT] = (adc_count > OVER_LIMIT);
                    ev[IRQ_LOW_BIT] = (adc_count <= LOW_LIMIT);
                end
            end
            DONE: begin
                st_nxt.phase = IDLE;
            end
        endcase
        // apb read data, held through the access phase
        if (!acc) begin
            st_nxt.rdata = '0;
        end
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                CTRL_OFS: st_nxt.rdata = st_r.ctrl;
                STAT_OFS: st_nxt.rdata = {28'h0, st_r.busy, st_r.low, st_r.over, st_r.neg};
                IRQ_STAT_OFS: st_nxt.rdata = {29'h0, st_r.ist};
                IRQ_MASK_OFS: st_nxt.rdata = {29'h0, st_r.imask};
                RESULT_OFS: st_nxt.rdata = {17'h0, st_r.result};
                DISP_OFS: st_nxt.rdata = {14'h0, leading_digit, 4'h0, digits_bcd};
                SAMPLE_OFS: st_nxt.rdata = {16'h0, st_r.nsample};
                default: st_nxt.rdata = '0;
            endcase
        end
        // apb writes and read-to-clear, set wins over clear
        // writes land only in the access cycle, once per transfer
        if (acc && pwrite) begin
            if (paddr == CTRL_OFS) begin
                st_nxt.ctrl = {28'h0, pwdata[3:0]};
            end
            if (paddr == IRQ_MASK_OFS) begin
                st_nxt.imask = pwdata[IRQ_W-1:0];
            end
        end
        if (acc && !pwrite && paddr == IRQ_STAT_OFS) begin
            st_nxt.ist = ev;
        end else begin
            st_nxt.ist = st_r.ist | ev;
        end
    end

    // ****************************************************
    // registers
    // ****************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{s1: 9'h1fe, s2: 9'h1fe, phase: IDLE, cnt: 32'h0, result: 15'h0, neg: 1'b0,
                      over: 1'b0, low: 1'b0, over_pend: 1'b0, busy: 1'b0, ctrl: CTRL_RESET,
                      ist: 3'h0, imask: 3'h0, rdata: 32'h0, nsample: 16'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************
    // readout decode
    // ****************************************************
    always_comb begin
        // binary count split into digits
        d0 = 4'(st_r.result % 15'd10);
        d1 = 4'((st_r.result / 15'd10) % 15'd10);
        d2 = 4'((st_r.result / 15'd100) % 15'd10);
        d3 = 4'((st_r.result / 15'd1000) % 15'd10);
        test_on = st_r.ctrl[CTRL_TEST_EN_BIT] & (sync_test == st_r.ctrl[CTRL_TEST_POL_BIT]);
        blank = st_r.ctrl[CTRL_BLANK_EN_BIT] & ~sync_off_n;
        leading_digit = {1'b0, d3 != 4'h0};
        digits_bcd = {d2, d1, d0};
        digit_blank = 3'h0;
        sign_plus = sync_sign_en & ~st_r.neg;
        sign_minus = sync_sign_en & st_r.neg;
        if (test_on) begin
            leading_digit = 2'h1;
            digits_bcd = 12'h888;
        end else if (st_r.result > FULL_SCALE && !st_r.neg) begin
            leading_digit = 2'h1;
            digit_blank = 3'h7;
            sign_plus = 1'b1;
            sign_minus = 1'b0;
        end else if (st_r.result > FULL_SCALE && st_r.neg) begin
            leading_digit = 2'h1;
            digit_blank = 3'h7;
            sign_minus = 1'b1;
            sign_plus = 1'b0;
        end
        if (blank && !test_on) begin
            leading_digit = 2'h0;
            digit_blank = 3'h7;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign radix_on = ~sync_radix_n;
    assign sign_out_n = ~st_r.neg;
    assign low_reading_flag = st_r.low;
    assign over_limit_flag = st_r.over;
    assign conv_active = st_r.busy;
    assign prdata = st_r.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign irq = |(st_r.ist & st_r.imask);
endmodule

/* File: shared/meter_pkg.sv */
// constants, register map and types of the panel meter control block
// ****************************************************************
// Function
// - active-low variant: high or open runs continuously
// - active-low variant: low freezes last sample
// - other variant: low runs, high freezes
// - blanking hides digits, keeps points and sign
// - sign output low for negative, valid at zero
// - segment check shows all-segments test pattern
// - four active-low radix selects, one point each
// - low-reading flag high at 1800 or below
// - over-limit flag high above 19999 counts
// - conversion-active high until conversion or measurement ends
// - overscale shows plus, leading 1, blanks rest
// - underscale shows minus, leading 1, blanks rest
// - plus/minus sign shown, suppressible by enable except in overscale; the code also forces the minus in underscale
// - three full digits plus leading one digit
// ****************************************************************
package meter_pkg;
    // ************************
    // register offsets
    // ************************
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h008;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h00c;
    localparam logic [11:0] RESULT_OFS = 12'h010;
    localparam logic [11:0] DISP_OFS = 12'h014;
    localparam logic [11:0] SAMPLE_OFS = 12'h018;
    // ctrl field positions
    localparam int CTRL_VARIANT_BIT = 0;
    localparam int CTRL_TEST_POL_BIT = 1;
    localparam int CTRL_TEST_EN_BIT = 2;
    localparam int CTRL_BLANK_EN_BIT = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_000c;
    // irq bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_OVER_BIT = 1;
    localparam int IRQ_LOW_BIT = 2;
    localparam int IRQ_W = 3;
    // ************************
    // counts
    // ************************
    localparam logic [14:0] OVER_LIMIT = 15'h4e1f;
    localparam logic [14:0] LOW_LIMIT = 15'h0708;
    localparam logic [14:0] FULL_SCALE = 15'h07cf;
    // timing: sampling 83.3 ms, conversion 333 ms at 125 MHz
    localparam real CLK_NS = 8.0;
    localparam real SIG_INT_MS = 83.3;
    localparam real CONV_MS = 333.0;
    localparam int SIG_CYCLES = int'(SIG_INT_MS * 1.0e6 / CLK_NS);
    localparam int CONV_CYCLES = int'(CONV_MS * 1.0e6 / CLK_NS);
    localparam int REF_CYCLES = CONV_CYCLES - SIG_CYCLES;
    // ************************
    // types
    // ************************
    typedef enum logic [1:0] {IDLE, SIG_INT, REF_INT, DONE} phase_type;
endpackage

/* File: sim/meter_ctrl_assertions.sv */
// port checks of the meter control block
`timescale 1ns/1ps
module meter_ctrl_checker (
    input wire logic pclk, presetn, conv_active, low_reading_flag, over_limit_flag, seg_check, readout_off_n,
    input wire logic [3:0] radix_sel_n, radix_on,
    input wire logic [1:0] leading_digit,
    input wire logic [11:0] digits_bcd,
    input wire logic [2:0] digit_blank
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence conv_start; $rose(conv_active); endsequence
    a_low_clear: assert property ($fell(low_reading_flag) |-> conv_start) else $error("low clear");
    a_low_set: assert property ($rose(low_reading_flag) |-> $fell(conv_active)) else $error("low set");
    a_over_clear: assert property ($fell(over_limit_flag) |-> $past(conv_active, 3)) else $error("over clear");
    a_over_set: assert property ($rose(over_limit_flag) |-> $fell(conv_active)) else $error("over set");
    a_busy_len: assert property (conv_start |-> conv_active [*8]) else $error("busy short");
    a_radix_map: assert property ((seg_check && $stable(radix_sel_n)) [*3] |-> radix_on == ~radix_sel_n)
        else $error("radix");
    a_seg_test: assert property ((!seg_check) [*3] |-> {leading_digit, digits_bcd} == 14'h1888) else $error("test");
    a_blank_all: assert property ((!readout_off_n && seg_check) [*3] |-> digit_blank == 3'h7) else $error("blank");
endmodule
bind meter_ctrl meter_ctrl_checker chk (.*);

/* File: sim/meter_far.sv */
// far-side model: converter result and front-panel levels
`timescale 1ns/1ps
module meter_far (
    input wire logic pclk,
    output logic [14:0] adc_count,
    output logic adc_negative, run_freeze, readout_off_n, seg_check, sign_show_en,
    output logic [3:0] radix_sel_n
);
    initial {adc_negative, adc_count, run_freeze, readout_off_n, seg_check, sign_show_en, radix_sel_n} = 24'h0000ff;
    // run, lit, test, sign, points; held until synced
    task automatic pins(input logic [7:0] v);
        @(posedge pclk);
        {run_freeze, readout_off_n, seg_check, sign_show_en, radix_sel_n} <= v;
        repeat (4) @(posedge pclk);
        #1;
    endtask
    task automatic put(input logic [15:0] v);
        @(posedge pclk);
        {adc_negative, adc_count} <= v;
    endtask
endmodule

/* File: sim/tb_meter_ctrl.sv */
// bench of the meter control block
`timescale 1ns/1ps
module tb_meter_ctrl;
    import meter_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, digits_bcd;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, sign_out_n, low_reading_flag, over_limit_flag, conv_active, sign_plus, sign_minus, irq;
    logic [1:0] leading_digit;
    logic [2:0] digit_blank;
    logic [3:0] radix_on;
    wire logic [14:0] adc_count;
    wire logic adc_negative, run_freeze, readout_off_n, seg_check, sign_show_en;
    wire logic [3:0] radix_sel_n;
    int miscompares = 0, checks = 0;
    meter_ctrl #(.SIG_LEN(4), .REF_LEN(8)) DUT (.*);
    meter_far far (.*);
    initial forever #4 pclk = ~pclk;
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        end_of_test();
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) miscompares++;
        if (seen !== exp) $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic conv_wait;
        repeat (2) @(negedge conv_active);
        #1;
    endtask
    task automatic t_read;
        logic [15:0] cs [7] = '{16'd1801, 16'd1800, 16'd0, 16'd19999, 16'd20000, 16'h81f4, 16'h89c4};
        logic [14:0] c;
        logic n, big;
        for (int i = 0; i < 7; i++) begin
            {n, c} = cs[i];
            far.put(cs[i]);
            conv_wait();
            big = c > 15'd1999;
            chk(conv_active, 1'b0);
            chk(leading_digit, big ? 1 : c / 1000);
            chk(digit_blank, big ? 7 : 0);
            if (!big) chk(digits_bcd, {4'(c / 100 % 10), 4'(c / 10 % 10), 4'(c % 10)});
            chk({sign_plus, sign_minus, sign_out_n}, {!n, n, !n});
            if (!n) chk({low_reading_flag, over_limit_flag}, {c <= 1800, c > 19999});
        end
    endtask
    task automatic t_hold;
        apb(0, 12'h0fc, 32'h0);
        chk(rd, 32'h0);
        apb(1, IRQ_MASK_OFS, 32'h1);
        far.pins(8'h7f);
        repeat (30) @(posedge pclk);
        far.put(16'd1234);
        repeat (30) @(posedge pclk);
        #1;
        chk({conv_active, digit_blank, sign_minus, irq}, 6'h1f);
        apb(1, IRQ_MASK_OFS, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1, IRQ_MASK_OFS, 32'h1);
        apb(0, IRQ_STAT_OFS, 32'h0);
        chk(rd[0], 1'b1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        apb(1, CTRL_OFS, 32'hd);
        conv_wait();
        chk({leading_digit, digits_bcd}, 14'h1234);
        apb(1, CTRL_OFS, CTRL_RESET);
    endtask
    task automatic t_panel;
        far.pins(8'h3f);
        chk({digit_blank, sign_plus, digits_bcd}, 16'hf234);
        for (int i = 0; i < 4; i++) begin
            far.pins({4'h3, ~(4'h1 << i)});
            chk(radix_on, 4'h1 << i);
        end
        far.pins(8'h6f);
        chk({sign_plus, sign_minus}, 2'b00);
        far.pins(8'h5f);
        chk({leading_digit, digits_bcd}, 14'h1888);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_read();
        t_hold();
        t_panel();
        end_of_test();
    end
endmodule
